// ==== dv/osc_ctrl_assertions.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module osc_ctrl_chk
#(
  parameter PLL_START_CYCLES = 500
)
(
  input wire        ref_clk,
  input wire        nrst,
  input wire        warm_rst,
  input wire [3:0]  addr,
  input wire [15:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [15:0] rdata,
  input wire [2:0]  config_source,
  input wire [1:0]  fail_safe_monitor,
  input wire        pll_locked_pin,
  input wire        clock_fail_pin,
  input wire        xtal_tick_pin,
  input wire [2:0]  osc_select,
  input wire        pll_enable,
  input wire        aux_loop_enable,
  input wire        aux_from_primary,
  input wire [4:0]  aux_multiplier,
  input wire        pps_write_en,
  input wire [15:0] pps_wdata,
  input wire        pps_rejected,
  input wire        ref_clk_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_pps_verdict: assert property (wr && addr == 4'h4 |=> pps_write_en != pps_rejected)
    else $error("pin-select write without one verdict");
  chk_pps_quiet: assert property (!(wr && addr == 4'h4) |=> !pps_write_en && !pps_rejected)
    else $error("pin-select pulse without a write");
  chk_pps_data: assert property (pps_write_en |-> pps_wdata == $past(wdata))
    else $error("pin-select data differs from written word");
  chk_read_idle: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside the read slot");
  chk_unimpl_zero: assert property (rd && addr == 4'h0 |=> (rdata & 16'h8816) == 16'h0000)
    else $error("unimplemented control bits read as one");
  chk_pll_match: assert property ($stable(osc_select) [*3]
    |-> pll_enable == (osc_select == 3'h1 || osc_select == 3'h3))
    else $error("loop enable disagrees with active source");
  chk_aux_mult: assert property ($past(nrst) |-> aux_multiplier == 5'h10)
    else $error("auxiliary multiplier is not sixteen");
  chk_por_source: assert property ($rose(nrst) |-> ##2
    osc_select == $past(config_source, 2))
    else $error("power-on source not taken from strap");
  chk_aux_follow: assert property (wr && addr == 4'h2 |-> ##2
    {aux_loop_enable, aux_from_primary} == $past(wdata[1:0], 2))
    else $error("auxiliary controls ignore the write");
  cov_pps_ok: cover property (pps_write_en);
  cov_pps_refused: cover property (pps_rejected);
  cov_pll_source: cover property (pll_enable);
endmodule // osc_ctrl_chk

bind osc_ctrl osc_ctrl_chk #(.PLL_START_CYCLES(PLL_START_CYCLES)) osc_ctrl_chk_inst (
  .ref_clk(ref_clk), .nrst(nrst), .warm_rst(warm_rst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .config_source(config_source), .fail_safe_monitor(fail_safe_monitor),
  .pll_locked_pin(pll_locked_pin), .clock_fail_pin(clock_fail_pin),
  .xtal_tick_pin(xtal_tick_pin), .osc_select(osc_select), .pll_enable(pll_enable),
  .aux_loop_enable(aux_loop_enable), .aux_from_primary(aux_from_primary),
  .aux_multiplier(aux_multiplier), .pps_write_en(pps_write_en), .pps_wdata(pps_wdata),
  .pps_rejected(pps_rejected), .ref_clk_out(ref_clk_out));

// ==== dv/oscillator_select_control_tb.sv ====
`timescale 1ns/100ps
`include "osc_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module oscillator_select_control_tb;
  reg         ref_clk = 1'b0;
  reg         nrst = 1'b0;
  reg         warm_rst = 1'b0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         pll_locked_pin = 1'b0;
  reg         clock_fail_pin = 1'b0;
  reg         xtal_tick_pin = 1'b0;
  reg  [1:0]  fail_safe_sel = 2'h1;
  reg  [2:0]  cfg_src = 3'h2;
  reg  [3:0]  addr = 4'h0;
  reg  [15:0] wdata = 16'h0000;
  reg  [15:0] seen;
  reg  [15:0] lf = 16'h6FD2;
  wire [15:0] rdata;
  wire [15:0] pps_wdata;
  wire [2:0]  osc_select;
  wire [4:0]  aux_multiplier;
  wire        pll_enable, aux_loop_enable, aux_from_primary;
  wire        pps_write_en, pps_rejected, ref_clk_out;
  integer     fail_count = 0, check_count = 0, n, i;
  integer     cur_m = 2, req_m = 2, lk_m = 0, io_m = 0;
  always #2 ref_clk = ~ref_clk;
  // A short start-up count keeps the lock-bit scenario within a few dozen cycles.
  osc_ctrl #(.PLL_START_CYCLES(8)) osc_ctrl_inst (
    .ref_clk(ref_clk), .nrst(nrst), .warm_rst(warm_rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .config_source(cfg_src), .fail_safe_monitor(fail_safe_sel),
    .pll_locked_pin(pll_locked_pin), .clock_fail_pin(clock_fail_pin),
    .xtal_tick_pin(xtal_tick_pin),
    .osc_select(osc_select), .pll_enable(pll_enable), .aux_loop_enable(aux_loop_enable),
    .aux_from_primary(aux_from_primary), .aux_multiplier(aux_multiplier),
    .pps_write_en(pps_write_en), .pps_wdata(pps_wdata), .pps_rejected(pps_rejected),
    .ref_clk_out(ref_clk_out));
////////////////////////////////////////////////////////////////////////////////
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [15:0] exp_ctl();
    exp_ctl = {1'b0, cur_m[2:0], 1'b0, req_m[2:0], lk_m[0], io_m[0], 6'h00};
  endfunction
  task chk(input [15:0] s, input [15:0] e, input string nm);
    check_count = check_count + 1;
    if (s !== e)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task bus(input w, input r, input [3:0] a, input [15:0] d);
    @(posedge ref_clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask
  task rdreg(input [3:0] a);
    bus(1'b0, 1'b1, a, 16'h0000);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    #1 seen = rdata;
  endtask
  // The key pair must be two back-to-back writes, and the control write must follow KEY2 within six cycles.
  task ctl(input [15:0] d);
    bus(1'b1, 1'b0, `OSC_ADDR_UNLOCK, `OSC_KEY1);
    bus(1'b1, 1'b0, `OSC_ADDR_UNLOCK, `OSC_KEY2);
    bus(1'b1, 1'b0, `OSC_ADDR_CTRL, d);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
  endtask
  // Both lock bits are written back as they stand, so a switch request never clears them.
  task swit(input [2:0] s);
    ctl({5'h00, s, lk_m[0], io_m[0], 6'h01});
    req_m = s;
    n = 0;
    seen = 16'h0001;
    while (seen[0] !== 1'b0 && n < 40)
    begin
      rdreg(`OSC_ADDR_CTRL);
      n = n + 1;
    end
    if (seen[0] !== 1'b0)
    begin
      fail_count = fail_count + 1;
      end_sim();
    end
  endtask
  task pps(input exp_ok);
    lf = lfsr(lf);
    bus(1'b1, 1'b0, `OSC_ADDR_PPS, lf);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    #1 chk({14'h0, pps_write_en, pps_rejected}, {14'h0, exp_ok, !exp_ok}, "pps");
    if (exp_ok)
      chk(pps_wdata, lf, "pps_data");
  endtask
  // Counts rising edges of the reference output; xt lets a crystal run at a quarter rate.
  task refrun(input integer cyc, input xt);
    #1 n = 0;
    for (i = 0; i < cyc; i = i + 1)
    begin
      seen[0] = ref_clk_out;
      @(posedge ref_clk);
      xtal_tick_pin <= xt & i[1];
      #1 n = n + ((ref_clk_out === 1'b1 && seen[0] === 1'b0) ? 1 : 0);
    end
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdreg(`OSC_ADDR_CTRL);
    chk(seen & 16'hFFDF, exp_ctl(), "ctrl_por");
    chk(seen & 16'h8816, 16'h0000, "unimpl");
    chk({13'h0, osc_select}, 16'h0002, "osc_sel");
    rdreg(4'hF);
    chk(seen, 16'h0000, "unmapped");
    bus(1'b1, 1'b0, `OSC_ADDR_CTRL, 16'h0040);
    rdreg(`OSC_ADDR_CTRL);
    chk(seen & 16'hFFDF, exp_ctl(), "no_key");
    pps(1'b1);
    swit(3'h3);
    cur_m = 3;
    chk(seen & 16'hFFDF, exp_ctl(), "to_pll");
    repeat (20) @(posedge ref_clk);
    rdreg(`OSC_ADDR_CTRL);
    chk({15'h0, seen[5]}, 16'h0001, "lock_on");
    chk({13'h0, osc_select}, 16'h0003, "osc_sel");
    // Passing through plain fast RC keeps the switch between loop sources legal.
    swit(3'h0);
    cur_m = 0;
    repeat (20) @(posedge ref_clk);
    rdreg(`OSC_ADDR_CTRL);
    chk(seen & 16'hFFFF, exp_ctl(), "lock_off");
    ctl(16'h00C0);
    lk_m = 1;
    io_m = 1;
    swit(3'h2);
    chk(seen & 16'hFFDF, exp_ctl(), "locked");
    pps(1'b0);
    @(posedge ref_clk);
    warm_rst <= 1'b1;
    @(posedge ref_clk);
    warm_rst <= 1'b0;
    rdreg(`OSC_ADDR_CTRL);
    chk(seen & 16'hFFDF, exp_ctl(), "warm");
    @(posedge ref_clk);
    clock_fail_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    clock_fail_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rdreg(`OSC_ADDR_CTRL);
    chk({15'h0, seen[3]}, 16'h0001, "fail_flag");
    ctl({5'h00, req_m[2:0], lk_m[0], io_m[0], 6'h00});
    rdreg(`OSC_ADDR_CTRL);
    chk(seen & 16'hFFDF, exp_ctl(), "fail_clear");
    // Outside the no-monitor setting the switch lock no longer holds the source.
    @(posedge ref_clk);
    fail_safe_sel <= 2'h0;
    swit(3'h2);
    cur_m = 2;
    chk(seen & 16'hFFDF, exp_ctl(), "lock_moot");
    bus(1'b1, 1'b0, `OSC_ADDR_AUX, 16'h0003);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    @(posedge ref_clk);
    #1 chk({14'h0, aux_loop_enable, aux_from_primary}, 16'h0003, "aux");
    chk({11'h0, aux_multiplier}, 16'h0010, "aux_mult");
    bus(1'b1, 1'b0, `OSC_ADDR_REF, 16'h8000);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (4) @(posedge ref_clk);
    refrun(32, 1'b0);
    chk({15'h0, n >= 15 && n <= 16}, 16'h0001, "ref_out");
    // Crystal source with scale 1: one output period spans four crystal ticks.
    bus(1'b1, 1'b0, `OSC_ADDR_REF, 16'hC001);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    refrun(64, 1'b1);
    chk({15'h0, n >= 3 && n <= 4}, 16'h0001, "ref_xtal");
    @(posedge ref_clk);
    nrst <= 1'b0;
    cfg_src <= 3'h5;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cur_m = 5;
    req_m = 5;
    lk_m = 0;
    io_m = 0;
    rdreg(`OSC_ADDR_CTRL);
    chk(seen, exp_ctl(), "por_again");
    chk({13'h0, osc_select}, 16'h0005, "osc_again");
    end_sim();
  end
endmodule // oscillator_select_control_tb

// ==== verilog/osc_ctrl.v ====
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "osc_defines.vh"
module osc_ctrl
#(
  parameter PLL_START_CYCLES = (`OSC_PLL_START_NS + `OSC_CLK_PERIOD_NS - 1) / `OSC_CLK_PERIOD_NS
)
(
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        warm_rst,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire [2:0]  config_source,
  input  wire [1:0]  fail_safe_monitor,
  input  wire        pll_locked_pin,
  input  wire        clock_fail_pin,
  input  wire        xtal_tick_pin,
  output reg  [2:0]  osc_select,
  output reg         pll_enable,
  output reg         aux_loop_enable,
  output reg         aux_from_primary,
  output reg  [4:0]  aux_multiplier,
  output reg         pps_write_en,
  output reg  [15:0] pps_wdata,
  output reg         pps_rejected,
  output reg         ref_clk_out
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'b001;
  localparam ST_SWAP = 3'b010;
  localparam ST_DONE = 3'b100;
  reg  [2:0]  state;
  reg  [2:0]  current_source_field;
  reg  [2:0]  requested_source_field;
  reg         clock_switch_lock;
  reg         pin_select_lock;
  reg         clock_fail_flag;
  reg         switch_request_bit;
  reg  [1:0]  unlock_stage;
  reg  [2:0]  unlock_timer;
  reg  [7:0]  swap_cnt;
  reg  [15:0] pll_timer;
  reg         pll_ready;
  reg         cfg_loaded;
  reg         aux_en;
  reg         aux_pri;
  reg         ref_en;
  reg         ref_src_xtal;
  reg  [7:0]  ref_scale;
  reg         pps_locked_hit;
  reg         xtal_prev;
  wire        pll_locked_s;
  wire        clock_fail_s;
  wire        xtal_s;
  wire        unlocked;
  wire        ctrl_wr;
  wire        pll_src;
  wire        ref_tick;
  wire        ref_wire;
  wire [15:0] ctrl_val;
  reg  [15:0] next_rdata;
  ////////////////////////////////////////////////////////////////////////////
  osc_sync3 #(.W(3)) u_sync
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       ({pll_locked_pin, clock_fail_pin, xtal_tick_pin}),
    .q       ({pll_locked_s, clock_fail_s, xtal_s})
  );
  ////////////////////////////////////////////////////////////////////////////
  // Unlock: KEY1 then KEY2 to the unlock address opens a short write window.
  assign unlocked = (unlock_timer != 3'h0);
  assign ctrl_wr  = wr && (addr == `OSC_ADDR_CTRL) && unlocked;
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      unlock_stage <= 2'h0;
      unlock_timer <= 3'h0;
    end
    else if (warm_rst)
    begin
      unlock_stage <= 2'h0;
      unlock_timer <= 3'h0;
    end
    else
    begin
      if (wr && addr == `OSC_ADDR_UNLOCK && wdata == `OSC_KEY1)
        unlock_stage <= 2'h1;
      else if (wr && addr == `OSC_ADDR_UNLOCK && wdata == `OSC_KEY2 && unlock_stage == 2'h1)
        unlock_stage <= 2'h2;
      else if (wr)
        unlock_stage <= 2'h0;
      if (wr && addr == `OSC_ADDR_UNLOCK && wdata == `OSC_KEY2 && unlock_stage == 2'h1)
        unlock_timer <= `OSC_UNLOCK_WIN;
      else if (ctrl_wr)
        unlock_timer <= 3'h0;
      else if (unlocked)
        unlock_timer <= unlock_timer - 3'h1;
    end
  ////////////////////////////////////////////////////////////////////////////
  // Control register: only nrst (power-on) resets it; warm_rst leaves it alone.
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      cfg_loaded             <= 1'b0;
      requested_source_field <= `OSC_SRC_FASTRC;
      current_source_field   <= `OSC_SRC_FASTRC;
      clock_switch_lock      <= 1'b0;
      pin_select_lock        <= 1'b0;
      clock_fail_flag        <= 1'b0;
      switch_request_bit     <= 1'b0;
      state                  <= ST_IDLE;
      swap_cnt               <= 8'h00;
    end
    else
    begin
      // Straps cannot feed an async reset, so they load on the first clock after release.
      if (!cfg_loaded)
      begin
        cfg_loaded             <= 1'b1;
        requested_source_field <= config_source;
        current_source_field   <= config_source;
      end
      else if (ctrl_wr)
      begin
        requested_source_field <= wdata[`OSC_BIT_REQ_HI:`OSC_BIT_REQ_LO];
        pin_select_lock        <= wdata[`OSC_BIT_PINLOCK];
        // While fail-safe monitoring is off, a set switch lock stays until power-on.
        if (!(clock_switch_lock && fail_safe_monitor == `OSC_FAILSAFE_OFF))
          clock_switch_lock <= wdata[`OSC_BIT_SWLOCK];
      end
      // Set wins over a software clear in the same cycle.
      if (clock_fail_s)
        clock_fail_flag <= 1'b1;
      else if (ctrl_wr && !wdata[`OSC_BIT_FAIL])
        clock_fail_flag <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (ctrl_wr && wdata[`OSC_BIT_SWREQ] && cfg_loaded)
          begin
            // Locked source or a reserved code: the request is dropped.
            if ((clock_switch_lock && fail_safe_monitor == `OSC_FAILSAFE_OFF) ||
                wdata[`OSC_BIT_REQ_HI:`OSC_BIT_REQ_LO] == `OSC_SRC_RESVD)
              switch_request_bit <= 1'b0;
            else
            begin
              switch_request_bit <= 1'b1;
              swap_cnt           <= 8'h00;
              state              <= ST_SWAP;
            end
          end
        end
        ST_SWAP:
        begin
          swap_cnt <= swap_cnt + 8'h01;
          if (swap_cnt == `OSC_SWITCH_CYCLES - 8'h01)
            state <= ST_DONE;
        end
        ST_DONE:
        begin
          current_source_field <= requested_source_field;
          switch_request_bit   <= 1'b0;
          state                <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  ////////////////////////////////////////////////////////////////////////////
  // PLL lock status: start-up timer or external lock, cleared when PLL is off.
  assign pll_src = (current_source_field == `OSC_SRC_PRIPLL) ||
                   (current_source_field == `OSC_SRC_FASTRC_MUL);
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      pll_timer <= 16'h0000;
      pll_ready <= 1'b0;
    end
    else if (!pll_src)
    begin
      pll_timer <= 16'h0000;
      pll_ready <= 1'b0;
    end
    else if (pll_timer == PLL_START_CYCLES[15:0] - 16'h0001 || pll_locked_s)
      pll_ready <= 1'b1;
    else
    begin
      pll_timer <= pll_timer + 16'h0001;
      pll_ready <= 1'b0;
    end
  ////////////////////////////////////////////////////////////////////////////
  // Auxiliary loop, reference clock and pin-select configuration.
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      aux_en       <= 1'b0;
      aux_pri      <= 1'b0;
      ref_en       <= 1'b0;
      ref_src_xtal <= 1'b0;
      ref_scale    <= 8'h00;
    end
    else if (wr && addr == `OSC_ADDR_AUX)
    begin
      aux_en  <= wdata[1];
      aux_pri <= wdata[0];
    end
    else if (wr && addr == `OSC_ADDR_REF)
    begin
      ref_en       <= wdata[15];
      ref_src_xtal <= wdata[14];
      ref_scale    <= wdata[7:0];
    end
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
      xtal_prev <= 1'b0;
    else
      xtal_prev <= xtal_s;
  assign ref_tick = ref_src_xtal ? (xtal_s && !xtal_prev) : 1'b1;
  osc_refdiv u_refdiv
  (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .enable   (ref_en),
    .src_tick (ref_tick),
    .scale    (ref_scale),
    .ref_out  (ref_wire)
  );
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      pps_write_en   <= 1'b0;
      pps_wdata      <= 16'h0000;
      pps_rejected   <= 1'b0;
      pps_locked_hit <= 1'b0;
    end
    else
    begin
      pps_write_en   <= wr && addr == `OSC_ADDR_PPS && !pin_select_lock;
      pps_rejected   <= wr && addr == `OSC_ADDR_PPS && pin_select_lock;
      pps_locked_hit <= pps_locked_hit | (wr && addr == `OSC_ADDR_PPS && pin_select_lock);
      if (wr && addr == `OSC_ADDR_PPS)
        pps_wdata <= wdata;
    end
  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each registered.
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      osc_select       <= 3'h0;
      pll_enable       <= 1'b0;
      aux_loop_enable  <= 1'b0;
      aux_from_primary <= 1'b0;
      aux_multiplier   <= 5'h00;
      ref_clk_out      <= 1'b0;
    end
    else
    begin
      osc_select       <= current_source_field;
      pll_enable       <= pll_src;
      aux_loop_enable  <= aux_en;
      aux_from_primary <= aux_pri;
      aux_multiplier   <= `OSC_AUX_MULT;
      ref_clk_out      <= ref_wire;
    end
  ////////////////////////////////////////////////////////////////////////////
  assign ctrl_val = {1'b0, current_source_field, 1'b0, requested_source_field,
                     clock_switch_lock, pin_select_lock, pll_ready, 1'b0,
                     clock_fail_flag, 2'b00, switch_request_bit};
  always @*
  begin
    next_rdata = 16'h0000;
    case (addr)
      `OSC_ADDR_CTRL:   next_rdata = ctrl_val;
      `OSC_ADDR_UNLOCK: next_rdata = {13'h0, unlock_timer};
      `OSC_ADDR_AUX:    next_rdata = {14'h0, aux_en, aux_pri};
      `OSC_ADDR_REF:    next_rdata = {ref_en, ref_src_xtal, 6'h00, ref_scale};
      `OSC_ADDR_PPS:    next_rdata = {14'h0, pps_locked_hit, pin_select_lock};
      default:          next_rdata = 16'h0000;
    endcase
  end
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
      rdata <= 16'h0000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 16'h0000;
endmodule // osc_ctrl

// ==== verilog/osc_defines.vh ====
`ifndef OSC_DEFINES_VH
`define OSC_DEFINES_VH
`define OSC_ADDR_CTRL      4'h0
`define OSC_ADDR_UNLOCK    4'h1
`define OSC_ADDR_AUX       4'h2
`define OSC_ADDR_REF       4'h3
`define OSC_ADDR_PPS       4'h4
`define OSC_BIT_CUR_HI     14
`define OSC_BIT_CUR_LO     12
`define OSC_BIT_REQ_HI     10
`define OSC_BIT_REQ_LO     8
`define OSC_BIT_SWLOCK     7
`define OSC_BIT_PINLOCK    6
`define OSC_BIT_LOCK       5
`define OSC_BIT_FAIL       3
`define OSC_BIT_SWREQ      0
`define OSC_KEY1           16'h0046
`define OSC_KEY2           16'h0057
`define OSC_UNLOCK_WIN     3'h6
`define OSC_SRC_FASTRC     3'h0
`define OSC_SRC_FASTRC_MUL 3'h1
`define OSC_SRC_PRIPLL     3'h3
`define OSC_SRC_RESVD      3'h4
`define OSC_FAILSAFE_OFF   2'h1
`define OSC_SWITCH_CYCLES  8'h10
`define OSC_PLL_START_NS   2000
`define OSC_CLK_PERIOD_NS  4
`define OSC_AUX_MULT       5'h10
`endif

// ==== verilog/osc_refdiv.v ====
`timescale 1ns/100ps
module osc_refdiv
(
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire       enable,
  input  wire       src_tick,
  input  wire [7:0] scale,
  output reg        ref_out
);
  reg [7:0] cnt;
  // The output toggles every scale+1 source ticks, so the divide is 2*(scale+1).
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      cnt     <= 8'h00;
      ref_out <= 1'b0;
    end
    else if (!enable)
    begin
      cnt     <= 8'h00;
      ref_out <= 1'b0;
    end
    else if (src_tick)
    begin
      if (cnt >= scale)
      begin
        cnt     <= 8'h00;
        ref_out <= ~ref_out;
      end
      else
        cnt <= cnt + 8'h01;
    end
endmodule // osc_refdiv

// ==== verilog/osc_sync3.v ====
`timescale 1ns/100ps
module osc_sync3
#(
  parameter W = 1
)
(
  input  wire         ref_clk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  // A change counts only once the second and third stages agree.
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      q  <= {W{1'b0}};
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        q <= s3;
    end
endmodule // osc_sync3
